// [bench/rwpl_assertions.sv]
`timescale 1ns/1ps
`include "rwpl_map.vh"
// ------------------------------
// port checker for the lock
// ------------------------------
module rwpl_assertions (
  input wire        clock_in,
  input wire        nrst_in,
  input wire [15:0] reg_addr_in,
  input wire        reg_wr_in,
  input wire        reg_rd_in,
  input wire [15:0] reg_wdata_in,
  input wire [15:0] reg_rdata_out,
  input wire        prot_wr_in,
  input wire        prot_wr_grant_out,
  input wire        prot_wr_deny_out,
  input wire        unlocked_out,
  input wire        pw_active_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  // stored identifier and pin words; unlocked_out lags, so hiding is judged over two samples
  wire stored_rd = reg_rd_in && reg_addr_in >= `RWPL_A_NEWID0 && reg_addr_in <= `RWPL_A_NEWPIN_INV1
                   && reg_addr_in != `RWPL_A_PINCHG_SIG;
  wire login_rd  = reg_rd_in && reg_addr_in >= `RWPL_A_LOGIN_ID0 && reg_addr_in <= `RWPL_A_LOGIN_PIN1;
  property p_one_answer; prot_wr_in |=> prot_wr_grant_out ^ prot_wr_deny_out; endproperty
  a_one_answer: assert property (p_one_answer) else $error("protected request not answered once");
  property p_quiet; !prot_wr_in |=> !prot_wr_grant_out && !prot_wr_deny_out; endproperty
  a_quiet: assert property (p_quiet) else $error("grant or deny without request");
  property p_deny; prot_wr_in && !unlocked_out ##1 !unlocked_out |-> prot_wr_deny_out; endproperty
  a_deny: assert property (p_deny) else $error("locked write not denied");
  property p_grant; prot_wr_in && unlocked_out ##1 unlocked_out |-> prot_wr_grant_out; endproperty
  a_grant: assert property (p_grant) else $error("open write not granted");
  property p_hold; !reg_rd_in |=> $stable(reg_rdata_out); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_flags; reg_rd_in && reg_addr_in == `RWPL_A_FLAGS |=> reg_rdata_out == {15'h0000, pw_active_out}; endproperty
  a_flags: assert property (p_flags) else $error("flag word read wrong");
  property p_flags_inv; reg_rd_in && reg_addr_in == `RWPL_A_FLAGS_INV |=> reg_rdata_out == {15'h7FFF, !pw_active_out};
  endproperty
  a_flags_inv: assert property (p_flags_inv) else $error("flag inverse read wrong");
  property p_hidden; stored_rd && !unlocked_out ##1 !unlocked_out |-> reg_rdata_out == 16'h0000; endproperty
  a_hidden: assert property (p_hidden) else $error("stored password shown while locked");
  property p_login_wo; login_rd |=> reg_rdata_out == 16'h0000; endproperty
  a_login_wo: assert property (p_login_wo) else $error("login word readable");
  property p_open_flag; !pw_active_out |-> unlocked_out; endproperty
  a_open_flag: assert property (p_open_flag) else $error("checking off but gate closed");
  c_grant: cover property (prot_wr_grant_out);
  c_deny: cover property (prot_wr_deny_out);
  c_unlock: cover property ($rose(unlocked_out));
endmodule // rwpl_assertions

bind rwpl_lock rwpl_assertions chk (.clock_in(clock_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .prot_wr_in(prot_wr_in), .prot_wr_grant_out(prot_wr_grant_out), .prot_wr_deny_out(prot_wr_deny_out),
  .unlocked_out(unlocked_out), .pw_active_out(pw_active_out));

// [bench/rwpl_master.sv]
`timescale 1ns/1ps
`include "rwpl_map.vh"
// ------------------------------
// register bus master model
// ------------------------------
module rwpl_master (
  input  wire        clock_in,
  input  wire [15:0] rdata_in,
  output reg  [15:0] addr_out = 16'h0000,
  output reg         wr_out = 1'b0,
  output reg         rd_out = 1'b0,
  output reg  [15:0] wdata_out = 16'h0000
);
  // data bus shows the inverse once released, so a stale word never passes as valid
  task wr(input [15:0] a, input [15:0] d);
    begin
      @(posedge clock_in);
      addr_out  <= a;
      wdata_out <= d;
      wr_out    <= 1'b1;
      @(posedge clock_in);
      wr_out    <= 1'b0;
      wdata_out <= ~d;
    end
  endtask
  // read data lands on the strobe edge
  task rd(input [15:0] a, output [15:0] d);
    begin
      @(posedge clock_in);
      addr_out <= a;
      rd_out   <= 1'b1;
      @(posedge clock_in);
      rd_out <= 1'b0;
      #1 d = rdata_in;
    end
  endtask
  // identifier first, pin last; characters from the printable set only
  task login(input [15:0] i0, i1, p0, p1);
    begin
      wr(`RWPL_A_LOGIN_ID0, i0);
      wr(`RWPL_A_LOGIN_ID1, i1);
      wr(`RWPL_A_LOGIN_PIN0, p0);
      wr(`RWPL_A_LOGIN_PIN1, p1);
    end
  endtask
  // value words followed by their exact inverses
  task chg(input [15:0] b, w0, w1);
    begin
      wr(b, w0);
      wr(b + 16'h0001, w1);
      wr(b + 16'h0002, ~w0);
      wr(b + 16'h0003, ~w1);
    end
  endtask
endmodule // rwpl_master

// [bench/tb_top.sv]
`timescale 1ns/1ps
`include "rwpl_map.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
// ------------------------------
// lock testbench
// ------------------------------
module tb_top;
  reg         clock_in = 1'b0;
  reg         nrst_in = 1'b0;
  reg         prot_wr_in = 1'b0;
  reg  [15:0] v;
  wire [15:0] addr, wdata, rdata;
  wire        wr, rd, grant, deny, unl, pw;
  int         num_errors = 0, total_checks = 0, cyc = 0;
  rwpl_lock #(.UNLOCK_CYCLES(36'd50)) uut (.clock_in(clock_in), .nrst_in(nrst_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .prot_wr_in(prot_wr_in),
    .prot_wr_grant_out(grant), .prot_wr_deny_out(deny), .unlocked_out(unl), .pw_active_out(pw));
  rwpl_master mst (.clock_in(clock_in), .rdata_in(rdata), .addr_out(addr), .wr_out(wr), .rd_out(rd),
    .wdata_out(wdata));
  always #20 clock_in = ~clock_in;
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      complete_run;
    end
  end
  task complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cyc_wait(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task rchk(input [15:0] a, input [15:0] e);
    mst.rd(a, v);
    `CHK("rdata", e, v)
  endtask
  // one request cycle, answer looked at in the following cycle only
  task pchk(input g);
    @(posedge clock_in);
    prot_wr_in <= 1'b1;
    @(posedge clock_in);
    prot_wr_in <= 1'b0;
    #1;
    `CHK("grant", g, grant)
    `CHK("deny", !g, deny)
  endtask
  task good_login;
    mst.login(`RWPL_RST_ID0, `RWPL_RST_ID1, `RWPL_RST_PIN0, `RWPL_RST_PIN1);
    cyc_wait(4);
  endtask
  task t_locked;
    rchk(`RWPL_A_LOGIN_SIG, 16'h0000);
    rchk(`RWPL_A_LOGIN_SIG, 16'hFFFF);
    rchk(`RWPL_A_IDCHG_SIG, 16'h0000);
    mst.wr(`RWPL_A_PINCHG_SIG, 16'h0002);
    rchk(`RWPL_A_PINCHG_SIG, 16'h0002);
    rchk(`RWPL_A_LOGIN_PIN1, 16'h0000);
    pchk(1'b0);
    rchk(`RWPL_A_FLAGS, 16'h0001);
    rchk(`RWPL_A_FLAGS_INV, 16'hFFFE);
    rchk(`RWPL_A_NEWPIN0, 16'h0000);
    mst.wr(`RWPL_A_FLAGS, 16'h0000);
    mst.wr(`RWPL_A_FLAGS_INV, 16'hFFFF);
    rchk(`RWPL_A_FLAGS, 16'h0001);
    mst.login(`RWPL_RST_ID0, `RWPL_RST_ID1, 16'h3031, `RWPL_RST_PIN1);
    cyc_wait(4);
    `CHK("unlocked", 1'b0, unl)
    pchk(1'b0);
  endtask
  task t_open;
    good_login;
    `CHK("unlocked", 1'b1, unl)
    repeat (3) pchk(1'b1);
    rchk(`RWPL_A_NEWID0, `RWPL_RST_ID0);
    mst.wr(`RWPL_A_FLAGS_SIG, 16'h0005);
    rchk(`RWPL_A_FLAGS_SIG, 16'h0005);
    rchk(`RWPL_A_FLAGS_SIG, 16'h0004);
    // second login lands while the first window still runs, so only a reload keeps it open
    cyc_wait(20);
    good_login;
    cyc_wait(30);
    `CHK("unlocked", 1'b1, unl)
    cyc_wait(40);
    `CHK("unlocked", 1'b0, unl)
    pchk(1'b0);
  endtask
  // a bad character must leave the stored pin alone; reset brings the default back
  task t_change;
    good_login;
    mst.chg(`RWPL_A_NEWPIN0, 16'h3123, 16'h3334);
    rchk(`RWPL_A_NEWPIN0, 16'h3030);
    mst.chg(`RWPL_A_NEWPIN0, 16'h3132, 16'h3334);
    rchk(`RWPL_A_NEWPIN0, 16'h3132);
    rchk(`RWPL_A_NEWPIN_INV1, 16'hCCCB);
    mst.chg(`RWPL_A_NEWID0, 16'h4142, 16'h0043);
    rchk(`RWPL_A_NEWID0, 16'h4142);
    @(posedge clock_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'b1;
    cyc_wait(1);
    `CHK("unlocked", 1'b0, unl)
    good_login;
    `CHK("unlocked", 1'b1, unl)
  endtask
  task t_disable;
    mst.wr(`RWPL_A_FLAGS, 16'h0000);
    mst.wr(`RWPL_A_FLAGS_INV, 16'hFFFF);
    cyc_wait(2);
    `CHK("pw_active", 1'b0, pw)
    rchk(`RWPL_A_FLAGS, 16'h0000);
    cyc_wait(60);
    `CHK("unlocked", 1'b1, unl)
    pchk(1'b1);
    rchk(`RWPL_A_NEWPIN0, 16'h0000);
  endtask
  initial begin
    repeat (8) @(posedge clock_in);
    nrst_in <= 1'b1;
    t_locked;
    t_open;
    t_change;
    t_disable;
    complete_run;
  end
endmodule // tb_top

// [common/rwpl_map.vh]
`ifndef RWPL_MAP_VH
`define RWPL_MAP_VH

// ----------------------------------------------------------------------
// register offsets (word addresses on the register port)
// ----------------------------------------------------------------------
`define RWPL_A_LOGIN_SIG   16'hA100
`define RWPL_A_LOGIN_ID0   16'hA101
`define RWPL_A_LOGIN_ID1   16'hA102
`define RWPL_A_LOGIN_PIN0  16'hA103
`define RWPL_A_LOGIN_PIN1  16'hA104
`define RWPL_A_FLAGS_SIG   16'hA105
`define RWPL_A_FLAGS       16'hA106
`define RWPL_A_FLAGS_INV   16'hA107
`define RWPL_A_IDCHG_SIG   16'hA108
`define RWPL_A_NEWID0      16'hA109
`define RWPL_A_NEWID1      16'hA10A
`define RWPL_A_NEWID_INV0  16'hA10B
`define RWPL_A_NEWID_INV1  16'hA10C
`define RWPL_A_PINCHG_SIG  16'hA10D
`define RWPL_A_NEWPIN0     16'hA10E
`define RWPL_A_NEWPIN1     16'hA10F
`define RWPL_A_NEWPIN_INV0 16'hA110
`define RWPL_A_NEWPIN_INV1 16'hA111

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define RWPL_F_PW_ACTIVE   0
`define RWPL_RST_PW_ACTIVE 1'b1
`define RWPL_RST_ID0       16'h4C4F
`define RWPL_RST_ID1       16'h004E
`define RWPL_RST_PIN0      16'h3030
`define RWPL_RST_PIN1      16'h3030
`define RWPL_RST_SIG       16'h0000

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define RWPL_CLK_HZ        25000000
`define RWPL_UNLOCK_MIN    30
`define RWPL_UNLOCK_CYCLES (36'd60 * `RWPL_UNLOCK_MIN * `RWPL_CLK_HZ)

`endif

// [core/rwpl_lock.v]
`timescale 1ns/1ps
`include "rwpl_map.vh"

// ----------------------------------------------------------------------
// register map on the register port
// ----------------------------------------------------------------------
// 0xA100  login signature, each read steps it down by one
// 0xA101  login identifier word 0, write only
// 0xA102  login identifier word 1, write only
// 0xA103  login pin word 0, write only
// 0xA104  login pin word 1, write only; this write judges the login
// 0xA105  flag telegram signature
// 0xA106  protection flags, bit 0 enables password checking
// 0xA107  inverse of the flags; this write commits the pair
// 0xA108  identifier change signature
// 0xA109  new identifier word 0; reads the stored one while open
// 0xA10A  new identifier word 1; third character in the low byte
// 0xA10B  inverse of new identifier word 0
// 0xA10C  inverse of new identifier word 1; this write commits
// 0xA10D  pin change signature
// 0xA10E  new pin word 0; reads the stored one while open
// 0xA10F  new pin word 1
// 0xA110  inverse of new pin word 0
// 0xA111  inverse of new pin word 1; this write commits
// every other address reads as zero and ignores writes

// ----------------------------------------------------------------------
// timing at the register port
// ----------------------------------------------------------------------
// a write takes effect at the edge that samples its strobe
// read data appear at the edge of the read strobe and hold until the next read
// the gate opens two edges after the last login word
// a good login reloads the full window rather than adding to it
// the credentials never leave the block except through the open window

module rwpl_lock #(
  parameter [35:0] UNLOCK_CYCLES = `RWPL_UNLOCK_CYCLES
) (
  input  wire        clock_in,
  input  wire        nrst_in,
  input  wire [15:0] reg_addr_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  input  wire [15:0] reg_wdata_in,
  output reg  [15:0] reg_rdata_out,
  input  wire        prot_wr_in,
  output reg         prot_wr_grant_out,
  output reg         prot_wr_deny_out,
  output reg         unlocked_out,
  output reg         pw_active_out
);

  // ----------------------------------------------------------------------
  // character filter
  // ----------------------------------------------------------------------
  function char_ok;
    input [7:0] c;
    begin
      char_ok = ((c >= 8'h30) && (c <= 8'h39)) ||  // digits
                ((c >= 8'h41) && (c <= 8'h5A)) ||  // upper case letters
                ((c >= 8'h61) && (c <= 8'h7A)) ||  // lower case letters
                (c == 8'h20) ||                    // space
                (c == 8'h2F) ||                    // slash
                (c == 8'h2D) ||                    // minus
                (c == 8'h2B) ||                    // plus
                (c == 8'h25) ||                    // percent
                (c == 8'h26) ||                    // ampersand
                (c == 8'h3F) ||                    // question mark
                (c == 8'h21) ||                    // exclamation mark
                (c == 8'h2E) ||                    // full stop
                (c == 8'h28) ||                    // opening bracket
                (c == 8'h29);                      // closing bracket
    end
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg  [15:0] id0_q, id1_q, pin0_q, pin1_q;       // stored credentials
  reg  [15:0] lid0_q, lid1_q, lpin0_q;            // login staging
  reg  [15:0] nid0_q, nid1_q, nidi0_q;            // identifier change staging
  reg  [15:0] npin0_q, npin1_q, npini0_q;         // PIN change staging
  reg  [15:0] flags_stage_q;
  reg         pw_active_q;
  reg         login_ok_q;
  wire        window_open;
  wire        wr_ok;
  wire        login_match;
  wire [15:0] w_n;
  wire        wr_hit;

  assign w_n         = ~reg_wdata_in;
  // checking disabled opens writes and the gate, not the stored-word reads; otherwise only inside the window
  assign wr_ok       = !pw_active_q || window_open;
  assign login_match = (lid0_q == id0_q) && (lid1_q == id1_q) &&
                       (lpin0_q == pin0_q) && (reg_wdata_in == pin1_q);
  assign wr_hit      = reg_wr_in;

  // ----------------------------------------------------------------------
  // commit conditions, judged as the last word of a telegram arrives
  // ----------------------------------------------------------------------
  // the last word comes straight off the write bus, so it needs no staging
  wire        flags_commit;
  wire        id_chars_ok;
  wire        id_commit;
  wire        pin_chars_ok;
  wire        pin_commit;

  // a half-written pair or a stray upper bit leaves the flag as it was
  assign flags_commit = (w_n == flags_stage_q) && (flags_stage_q[15:1] == 15'h0000) && wr_ok;
  // three characters: two in word 0, one in the low byte of word 1
  assign id_chars_ok  = char_ok(nid0_q[15:8]) && char_ok(nid0_q[7:0]) && char_ok(nid1_q[7:0]) &&
                        (nid1_q[15:8] == 8'h00);
  assign id_commit    = wr_ok && (nidi0_q == ~nid0_q) && (w_n == nid1_q) && id_chars_ok;
  // four characters, two to a word, high byte first
  assign pin_chars_ok = char_ok(npin0_q[15:8]) && char_ok(npin0_q[7:0]) &&
                        char_ok(npin1_q[15:8]) && char_ok(npin1_q[7:0]);
  assign pin_commit   = wr_ok && (npini0_q == ~npin0_q) && (w_n == npin1_q) && pin_chars_ok;

  // ----------------------------------------------------------------------
  // unlock window timer
  // ----------------------------------------------------------------------
  rwpl_unlock_timer #(
    .UNLOCK_CYCLES (UNLOCK_CYCLES)
  ) u_timer (
    .clock_in      (clock_in),
    .nrst_in       (nrst_in),
    .start_in      (login_ok_q),
    .open_out      (window_open)
  );

  // ----------------------------------------------------------------------
  // signature registers, one per telegram
  // ----------------------------------------------------------------------
  localparam [63:0] SIG_ADDRS = {`RWPL_A_PINCHG_SIG, `RWPL_A_IDCHG_SIG,
                                 `RWPL_A_FLAGS_SIG, `RWPL_A_LOGIN_SIG};
  wire [63:0] sig_flat;
  wire [3:0]  sig_hit;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sig
      reg [15:0] val_q;
      assign sig_hit[gi]             = (reg_addr_in == SIG_ADDRS[gi*16 +: 16]);
      assign sig_flat[gi*16 +: 16]   = val_q;
      // write loads, each read steps the value down by one
      // a read of zero wraps to all ones; the master reloads before reuse
      always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
          val_q <= `RWPL_RST_SIG;
        end else if (reg_wr_in && sig_hit[gi]) begin
          val_q <= reg_wdata_in;
        end else if (reg_rd_in && sig_hit[gi]) begin
          val_q <= val_q - 16'h0001;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // login, flag and credential writes
  // ----------------------------------------------------------------------
  // reset is the restart: credentials and flag return to factory state,
  // and temporary states outside are cleared by the same reset
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      id0_q         <= `RWPL_RST_ID0;
      id1_q         <= `RWPL_RST_ID1;
      pin0_q        <= `RWPL_RST_PIN0;
      pin1_q        <= `RWPL_RST_PIN1;
      lid0_q        <= 16'h0000;
      lid1_q        <= 16'h0000;
      lpin0_q       <= 16'h0000;
      nid0_q        <= 16'h0000;
      nid1_q        <= 16'h0000;
      nidi0_q       <= 16'h0000;
      npin0_q       <= 16'h0000;
      npin1_q       <= 16'h0000;
      npini0_q      <= 16'h0000;
      flags_stage_q <= 16'h0000;
      pw_active_q   <= `RWPL_RST_PW_ACTIVE;
      login_ok_q    <= 1'b0;
    end else begin
      login_ok_q <= 1'b0;
      if (wr_hit) begin
        case (reg_addr_in)
          `RWPL_A_LOGIN_ID0:   lid0_q  <= reg_wdata_in;
          `RWPL_A_LOGIN_ID1:   lid1_q  <= reg_wdata_in;
          `RWPL_A_LOGIN_PIN0:  lpin0_q <= reg_wdata_in;
          // last PIN word completes the login; a mismatch does nothing
          `RWPL_A_LOGIN_PIN1:  login_ok_q <= login_match;
          `RWPL_A_FLAGS:       flags_stage_q <= reg_wdata_in;
          `RWPL_A_FLAGS_INV: begin
            // commit only with a true complement pair and write access
            if (flags_commit) begin
              pw_active_q <= flags_stage_q[`RWPL_F_PW_ACTIVE];
            end
          end
          `RWPL_A_NEWID0:      nid0_q  <= reg_wdata_in;
          `RWPL_A_NEWID1:      nid1_q  <= reg_wdata_in;
          `RWPL_A_NEWID_INV0:  nidi0_q <= reg_wdata_in;
          `RWPL_A_NEWID_INV1: begin
            // a new identifier leaves the open window running
            if (id_commit) begin
              id0_q <= nid0_q;
              id1_q <= nid1_q;
            end
          end
          `RWPL_A_NEWPIN0:     npin0_q  <= reg_wdata_in;
          `RWPL_A_NEWPIN1:     npin1_q  <= reg_wdata_in;
          `RWPL_A_NEWPIN_INV0: npini0_q <= reg_wdata_in;
          `RWPL_A_NEWPIN_INV1: begin
            // the new pin is asked for from the next login on
            if (pin_commit) begin
              pin0_q <= npin0_q;
              pin1_q <= npin1_q;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // protected area gate and status outputs
  // ----------------------------------------------------------------------
  // the gate holds no count of changes, so the window never closes early;
  // it also never touches temporary states, so expiry keeps them
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prot_wr_grant_out <= 1'b0;
      prot_wr_deny_out  <= 1'b0;
      unlocked_out      <= 1'b0;
      pw_active_out     <= `RWPL_RST_PW_ACTIVE;
    end else begin
      prot_wr_grant_out <= prot_wr_in && wr_ok;
      prot_wr_deny_out  <= prot_wr_in && !wr_ok;  // target left unchanged
      unlocked_out      <= wr_ok;
      pw_active_out     <= pw_active_q;
    end
  end

  // ----------------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------------
  reg [15:0] rd_d;
  integer    k;

  // reads never wait on the lock, so a locked master can still poll status
  always @* begin
    rd_d = 16'h0000;
    // login words are write-only and read as zero
    case (reg_addr_in)
      `RWPL_A_FLAGS:       rd_d = {15'h0000, pw_active_q};
      `RWPL_A_FLAGS_INV:   rd_d = ~{15'h0000, pw_active_q};
      `RWPL_A_NEWID0:      rd_d = window_open ? id0_q : 16'h0000;
      `RWPL_A_NEWID1:      rd_d = window_open ? id1_q : 16'h0000;
      `RWPL_A_NEWID_INV0:  rd_d = window_open ? ~id0_q : 16'h0000;
      `RWPL_A_NEWID_INV1:  rd_d = window_open ? ~id1_q : 16'h0000;
      `RWPL_A_NEWPIN0:     rd_d = window_open ? pin0_q : 16'h0000;
      `RWPL_A_NEWPIN1:     rd_d = window_open ? pin1_q : 16'h0000;
      `RWPL_A_NEWPIN_INV0: rd_d = window_open ? ~pin0_q : 16'h0000;
      `RWPL_A_NEWPIN_INV1: rd_d = window_open ? ~pin1_q : 16'h0000;
      default:             rd_d = 16'h0000;
    endcase
    for (k = 0; k < 4; k = k + 1) begin
      if (sig_hit[k]) begin
        rd_d = sig_flat[k*16 +: 16];   // value before the decrement
      end
    end
  end

  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_d;
    end
  end

endmodule // rwpl_lock

// [core/rwpl_unlock_timer.v]
`timescale 1ns/1ps
`include "rwpl_map.vh"

// ----------------------------------------------------------------------
// unlock window: reload on every good login, count down to relock
// ----------------------------------------------------------------------
module rwpl_unlock_timer #(
  parameter [35:0] UNLOCK_CYCLES = `RWPL_UNLOCK_CYCLES
) (
  input  wire        clock_in,
  input  wire        nrst_in,
  input  wire        start_in,
  output reg         open_out
);

  reg [35:0] count_q;

  // a fresh login always restarts from the full window
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_q  <= 36'h0;
      open_out <= 1'b0;
    end else if (start_in) begin
      count_q  <= UNLOCK_CYCLES - 36'h1;
      open_out <= 1'b1;
    end else if (count_q != 36'h0) begin
      count_q  <= count_q - 36'h1;
    end else begin
      open_out <= 1'b0;                  // expiry relocks
    end
  end

endmodule // rwpl_unlock_timer
